/* File: ddr_host_pkg.sv */
package ddr_host_pkg;

   // System clock and the divided memory clock
   localparam int SYS_PERIOD_PS = 25000;
   localparam int CK_DIV = 8;
   localparam int DIV_W = 3;
   localparam logic [DIV_W-1:0] CK_HIGH_PHASES = 3'h4;
   localparam logic [DIV_W-1:0] ISSUE_PHASE = 3'h3;
   localparam int TCK_PS = SYS_PERIOD_PS * CK_DIV;

   // Time to whole memory clocks, rounded up, never below one
   function automatic int to_ck(input int ps);
      int n;
      n = (ps + TCK_PS - 1) / TCK_PS;
      return (n < 1) ? 1 : n;
   endfunction

   function automatic int imax(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   // Analog minimums in picoseconds
   localparam int T_RCD_PS = 15000;
   localparam int T_RP_PS = 15000;
   localparam int T_RAS_PS = 35000;
   localparam int T_RC_PS = 50000;
   localparam int T_RRD_PS = 10000;
   localparam int T_FAW_PS = 40000;
   localparam int T_RTP_PS = 7500;
   localparam int T_WR_PS = 15000;
   localparam int T_WTR_PS = 7500;

   // Same minimums in memory clocks
   localparam int RCD_CK = to_ck(T_RCD_PS);
   localparam int RP_CK = to_ck(T_RP_PS);
   localparam int RAS_CK = to_ck(T_RAS_PS);
   localparam int RC_CK = to_ck(T_RC_PS);
   localparam int RRD_CK = to_ck(T_RRD_PS);
   localparam int FAW_CK = to_ck(T_FAW_PS);
   localparam int RTP_CK = to_ck(T_RTP_PS);
   localparam int WR_CK = to_ck(T_WR_PS);
   localparam int WTR_CK = to_ck(T_WTR_PS);

   // Latencies and derived command spacings, in memory clocks
   localparam int CL = 5;
   localparam int AL = 0;
   localparam int CWL = 5;
   localparam int RL = AL + CL;
   localparam int WL = AL + CWL;
   localparam int TCCD_CK = 4;
   localparam int BURST_CK = 4;
   localparam int RCD_EFF_CK = imax(RCD_CK - AL, 1);
   localparam int RD_TO_WR_CK = RL + TCCD_CK - WL + 2;
   localparam int RD_TO_PRE_CK = imax(4, AL + RTP_CK);
   localparam int WR_TO_PRE_CK = WL + BURST_CK + WR_CK;
   localparam int WR_TO_RD_CK = WL + BURST_CK + WTR_CK;
   localparam int RD_AP_CK = AL + imax(RTP_CK, 4);
   localparam int ZQINIT_CK = 512;
   localparam int ZQOPER_CK = 256;
   localparam int ZQCS_CK = 64;
   localparam int FAW_SLOTS = 4;
   localparam int BEATS_BL8 = 8;
   localparam int BEATS_BC4 = 4;

   // Widths
   localparam int CNT_W = 10;
   localparam int N_BANK = 8;
   localparam int BANK_W = 3;
   localparam int ROW_W = 14;
   localparam int COL_W = 10;
   localparam int DQ_W = 8;
   localparam int BEAT_W = 5;

   // Address bits with a command meaning
   localparam int AP_BIT = 10;
   localparam int BL_BIT = 12;

   // Pin codes {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] PIN_ACT = 4'h3;
   localparam logic [3:0] PIN_READ = 4'h5;
   localparam logic [3:0] PIN_WRITE = 4'h4;
   localparam logic [3:0] PIN_PRE = 4'h2;
   localparam logic [3:0] PIN_ZQ = 4'h6;
   localparam logic [3:0] PIN_NOP = 4'h7;
   localparam logic [3:0] PIN_DESEL = 4'hf;

   typedef enum logic [2:0] {
      REQ_NOP,
      REQ_ACT,
      REQ_READ,
      REQ_WRITE,
      REQ_PRE,
      REQ_ZQCL,
      REQ_ZQCS
   } req_cmd_type;

endpackage

/* File: bank_tracker.sv */
`timescale 1ns/1ps
module bank_tracker (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_tick,
   input wire logic i_act,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic i_pre,
   input wire logic i_auto_pre,
   input wire logic [ddr_host_pkg::ROW_W-1:0] i_row,
   output logic o_open,
   output logic [ddr_host_pkg::ROW_W-1:0] o_row,
   output logic o_act_ok,
   output logic o_rw_ok,
   output logic o_pre_ok,
   output logic o_idle_ok
);
   import ddr_host_pkg::*;

   logic [CNT_W-1:0] rcd, rc, ras, rp, rd_pre, wr_pre, ap;
   logic ap_busy;

   function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
      return (v == '0) ? v : v - 1'b1;
   endfunction

   // Open flag and open row
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_open <= 1'b0;
         o_row <= '0;
      end else if (i_tick) begin
         if (i_act) begin
            o_open <= 1'b1;
            o_row <= i_row;
         end else if (i_pre || ((i_read || i_write) && i_auto_pre)) begin
            o_open <= 1'b0;
         end
      end
   end

   // Spacing timers, each loaded with its count less one
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rcd <= '0;
         rc <= '0;
         ras <= '0;
         rd_pre <= '0;
         wr_pre <= '0;
      end else if (i_tick) begin
         rcd <= i_act ? CNT_W'(RCD_EFF_CK - 1) : dec(rcd);
         rc <= i_act ? CNT_W'(RC_CK - 1) : dec(rc);
         ras <= i_act ? CNT_W'(RAS_CK - 1) : dec(ras);
         rd_pre <= i_read ? CNT_W'(RD_TO_PRE_CK - 1) : dec(rd_pre);
         wr_pre <= i_write ? CNT_W'(WR_TO_PRE_CK - 1) : dec(wr_pre);
      end
   end

   // Auto precharge: start after latency, tRAS lockout, then tRP
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         ap <= '0;
         ap_busy <= 1'b0;
         rp <= '0;
      end else if (i_tick) begin
         if ((i_read || i_write) && i_auto_pre) begin
            ap_busy <= 1'b1;
            if (i_read) begin
               ap <= (CNT_W'(RD_AP_CK) > ras) ? CNT_W'(RD_AP_CK) : ras;
            end else begin
               ap <= (CNT_W'(WR_TO_PRE_CK) > ras) ? CNT_W'(WR_TO_PRE_CK) : ras;
            end
         end else begin
            ap <= dec(ap);
            if (ap_busy && ap <= CNT_W'(1)) begin
               ap_busy <= 1'b0;
            end
         end
         if (i_pre || (ap_busy && ap <= CNT_W'(1))) begin
            rp <= CNT_W'(RP_CK - 1);
         end else begin
            rp <= dec(rp);
         end
      end
   end

   assign o_act_ok = !o_open && rc == '0 && rp == '0 && !ap_busy;
   assign o_rw_ok = o_open && rcd == '0;
   assign o_pre_ok = ras == '0 && rd_pre == '0 && wr_pre == '0 && !ap_busy;
   assign o_idle_ok = !o_open && rp == '0 && !ap_busy;

endmodule // bank_tracker

/* File: read_capture.sv */
`timescale 1ns/1ps
module read_capture (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_dqs,
   input wire logic [ddr_host_pkg::DQ_W-1:0] i_dq,
   input wire logic i_add,
   input wire logic [ddr_host_pkg::BEAT_W-1:0] i_add_beats,
   output logic [ddr_host_pkg::DQ_W-1:0] o_data,
   output logic o_valid
);
   import ddr_host_pkg::*;

   logic dqs_s1, dqs_s2, dqs_s3;
   logic [DQ_W-1:0] dq_s1, dq_s2;
   logic [BEAT_W-1:0] owed;
   logic armed;
   logic [1:0] pend;
   logic edge_seen, take;

   // Two-stage synchronisers on strobe and data
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         dqs_s1 <= 1'b0;
         dqs_s2 <= 1'b0;
         dqs_s3 <= 1'b0;
         dq_s1 <= '0;
         dq_s2 <= '0;
      end else begin
         dqs_s1 <= i_dqs;
         dqs_s2 <= dqs_s1;
         dqs_s3 <= dqs_s2;
         dq_s1 <= i_dq;
         dq_s2 <= dq_s1;
      end
   end

   // Preamble holds strobe low, so the first rising edge arms capture
   assign edge_seen = dqs_s2 ^ dqs_s3;
   assign take = edge_seen && owed != '0 && (armed || dqs_s2);

   // Beats owed by issued reads; burst data is never cut short
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         owed <= '0;
         armed <= 1'b0;
      end else begin
         owed <= owed + (i_add ? i_add_beats : '0) - {{(BEAT_W-1){1'b0}}, take};
         if (take) begin
            armed <= (owed != BEAT_W'(1)) || i_add;
         end
      end
   end

   // Sample data two cycles after the strobe edge, near the eye centre
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         pend <= 2'h0;
         o_data <= '0;
         o_valid <= 1'b0;
      end else begin
         pend <= {pend[0], take};
         o_valid <= pend[1];
         if (pend[1]) begin
            o_data <= dq_s2;
         end
      end
   end

endmodule // read_capture

/* File: ddr_cmd_sched.sv */
// Behaviour
// - Calibration only with all banks precharged, tRP met.
// - Long calibration and short calibration with durations.
// - Channel quiet during calibration except calibration.
// - Calibration may overlap DLL reset and lock.
// - Self refresh exit needs explicit long calibration.
// - Shared resistor ranks never calibrate together.
// - CKE high, ODT off, bus idle in calibration; calibration is not held back while read data is still due on DQ.
// - Activate row before read/write, wait tRCD.
// - Additive latency allows early read or write.
// - Times become clocks by rounding up.
// - Read-read and write-write spaced by tCCD.
// - Precharge before new row; tRC between activates.
// - tRRD between activates; four per tFAW.
// - Reads tCCD apart stream; bursts never truncated.
// - Read to write spacing RL+tCCD-WL+2.
// - Read to precharge four clocks and tRTP.
// - No command to bank before tRP.
`timescale 1ns/1ps
module ddr_cmd_sched (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_req_valid,
   input wire ddr_host_pkg::req_cmd_type i_req_cmd,
   input wire logic [ddr_host_pkg::BANK_W-1:0] i_req_bank,
   input wire logic [ddr_host_pkg::ROW_W-1:0] i_req_row,
   input wire logic [ddr_host_pkg::COL_W-1:0] i_req_col,
   input wire logic i_req_auto_pre,
   input wire logic i_req_bc4,
   output logic o_req_ack,
   output logic o_req_reject,
   output logic o_zq_busy,
   output logic o_ck,
   output logic o_cke,
   output logic o_cs_n,
   output logic o_ras_n,
   output logic o_cas_n,
   output logic o_we_n,
   output logic [ddr_host_pkg::BANK_W-1:0] o_ba,
   output logic [ddr_host_pkg::ROW_W-1:0] o_addr,
   output logic o_odt,
   input wire logic i_dqs,
   input wire logic [ddr_host_pkg::DQ_W-1:0] i_dq,
   output logic [ddr_host_pkg::DQ_W-1:0] o_rd_data,
   output logic o_rd_valid
);
   import ddr_host_pkg::*;

   logic [DIV_W-1:0] div_cnt;
   logic [DIV_W-1:0] next_div;
   logic tick;
   logic [N_BANK-1:0] bank_hit;
   logic [N_BANK-1:0] open_vec, act_ok_vec, rw_ok_vec, pre_ok_vec, idle_ok_vec;
   logic [ROW_W-1:0] open_row [N_BANK];
   logic [CNT_W-1:0] rrd_cnt, rd_rd_cnt, wr_wr_cnt, rd_wr_cnt, wr_rd_cnt, zq_cnt;
   logic [CNT_W-1:0] faw_cnt [FAW_SLOTS];
   logic [FAW_SLOTS-1:0] faw_free;
   logic [FAW_SLOTS-1:0] faw_load;
   logic zq_first;
   logic legal, ready, fire;
   logic fire_act, fire_read, fire_write, fire_pre, fire_zq;
   logic [3:0] next_pins;
   logic [ROW_W-1:0] next_addr;
   logic rd_add;
   logic [BEAT_W-1:0] rd_beats;

   function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
      return (v == '0) ? v : v - 1'b1;
   endfunction

   // Memory clock divider; commands change mid-cycle, on the falling edge
   assign next_div = div_cnt + 1'b1;
   assign tick = (div_cnt == ISSUE_PHASE);

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         div_cnt <= '0;
         o_ck <= 1'b0;
      end else begin
         div_cnt <= next_div;
         o_ck <= (next_div < CK_HIGH_PHASES);
      end
   end

   // Clock enable held high from the first edge after reset; ODT kept off
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_cke <= 1'b0;
         o_odt <= 1'b0;
      end else begin
         o_cke <= 1'b1;
         o_odt <= 1'b0;
      end
   end

   // One tracker per bank
   genvar gb;
   generate
      for (gb = 0; gb < N_BANK; gb++) begin : g_bank
         assign bank_hit[gb] = (i_req_bank == BANK_W'(gb));
         bank_tracker u_bank (
            .i_clock(i_clock),
            .i_sys_rst(i_sys_rst),
            .i_tick(tick),
            .i_act(fire_act && bank_hit[gb]),
            .i_read(fire_read && bank_hit[gb]),
            .i_write(fire_write && bank_hit[gb]),
            .i_pre(fire_pre && bank_hit[gb]),
            .i_auto_pre(i_req_auto_pre),
            .i_row(i_req_row),
            .o_open(open_vec[gb]),
            .o_row(open_row[gb]),
            .o_act_ok(act_ok_vec[gb]),
            .o_rw_ok(rw_ok_vec[gb]),
            .o_pre_ok(pre_ok_vec[gb]),
            .o_idle_ok(idle_ok_vec[gb])
         );
      end
   endgenerate

   // Rolling four-activate window slots, first free slot takes the load
   always_comb begin
      faw_load = '0;
      for (int i = 0; i < FAW_SLOTS; i++) begin
         faw_free[i] = (faw_cnt[i] == '0);
      end
      for (int i = FAW_SLOTS - 1; i >= 0; i--) begin
         if (faw_free[i]) begin
            faw_load = '0;
            faw_load[i] = fire_act;
         end
      end
   end

   genvar gf;
   generate
      for (gf = 0; gf < FAW_SLOTS; gf++) begin : g_faw
         always_ff @(posedge i_clock) begin
            if (i_sys_rst) begin
               faw_cnt[gf] <= '0;
            end else if (tick) begin
               faw_cnt[gf] <= faw_load[gf] ? CNT_W'(FAW_CK - 1) : dec(faw_cnt[gf]);
            end
         end
      end
   endgenerate

   // Request legality: row state must suit the command
   always_comb begin
      legal = 1'b1;
      unique case (i_req_cmd)
         REQ_ACT: legal = !open_vec[i_req_bank];
         REQ_READ,
         REQ_WRITE: legal = open_vec[i_req_bank] && open_row[i_req_bank] == i_req_row;
         REQ_ZQCL,
         REQ_ZQCS: legal = (open_vec == '0);
         REQ_PRE: legal = 1'b1;
         REQ_NOP: legal = 1'b1;
      endcase
   end

   // Timing readiness; calibration blocks all but another calibration
   always_comb begin
      ready = 1'b0;
      unique case (i_req_cmd)
         REQ_ACT: ready = act_ok_vec[i_req_bank] && rrd_cnt == '0 && faw_free != '0;
         REQ_READ: ready = rw_ok_vec[i_req_bank] && rd_rd_cnt == '0 && wr_rd_cnt == '0;
         REQ_WRITE: ready = rw_ok_vec[i_req_bank] && wr_wr_cnt == '0 && rd_wr_cnt == '0;
         REQ_PRE: ready = pre_ok_vec[i_req_bank];
         REQ_ZQCL,
         REQ_ZQCS: ready = (idle_ok_vec == '1);
         REQ_NOP: ready = 1'b1;
      endcase
      if (zq_cnt != '0 && i_req_cmd != REQ_ZQCL && i_req_cmd != REQ_ZQCS) begin
         ready = 1'b0;
      end
   end

   assign fire = tick && i_req_valid && legal && ready;
   assign fire_act = fire && i_req_cmd == REQ_ACT;
   assign fire_read = fire && i_req_cmd == REQ_READ;
   assign fire_write = fire && i_req_cmd == REQ_WRITE;
   assign fire_pre = fire && i_req_cmd == REQ_PRE;
   assign fire_zq = fire && (i_req_cmd == REQ_ZQCL || i_req_cmd == REQ_ZQCS);

   // Channel-wide spacing timers in memory clocks
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rrd_cnt <= '0;
         rd_rd_cnt <= '0;
         wr_wr_cnt <= '0;
         rd_wr_cnt <= '0;
         wr_rd_cnt <= '0;
      end else if (tick) begin
         rrd_cnt <= fire_act ? CNT_W'(RRD_CK - 1) : dec(rrd_cnt);
         rd_rd_cnt <= fire_read ? CNT_W'(TCCD_CK - 1) : dec(rd_rd_cnt);
         wr_wr_cnt <= fire_write ? CNT_W'(TCCD_CK - 1) : dec(wr_wr_cnt);
         rd_wr_cnt <= fire_read ? CNT_W'(RD_TO_WR_CK - 1) : dec(rd_wr_cnt);
         wr_rd_cnt <= fire_write ? CNT_W'(WR_TO_RD_CK - 1) : dec(wr_rd_cnt);
      end
   end

   // Calibration interval; first long form after reset uses the init time
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         zq_cnt <= '0;
         zq_first <= 1'b1;
         o_zq_busy <= 1'b0;
      end else begin
         if (tick) begin
            if (fire_zq && i_req_cmd == REQ_ZQCL) begin
               zq_cnt <= zq_first ? CNT_W'(ZQINIT_CK) : CNT_W'(ZQOPER_CK);
               zq_first <= 1'b0;
            end else if (fire_zq) begin
               zq_cnt <= CNT_W'(ZQCS_CK);
            end else begin
               zq_cnt <= dec(zq_cnt);
            end
         end
         o_zq_busy <= (zq_cnt != '0) || fire_zq;
      end
   end

   // Pin code and address for the chosen command
   always_comb begin
      next_pins = PIN_NOP;
      next_addr = '0;
      if (fire) begin
         unique case (i_req_cmd)
            REQ_ACT: begin
               next_pins = PIN_ACT;
               next_addr = i_req_row;
            end
            REQ_READ,
            REQ_WRITE: begin
               next_pins = (i_req_cmd == REQ_READ) ? PIN_READ : PIN_WRITE;
               next_addr[COL_W-1:0] = i_req_col;
               next_addr[AP_BIT] = i_req_auto_pre;
               next_addr[BL_BIT] = !i_req_bc4;
            end
            REQ_PRE: next_pins = PIN_PRE;
            REQ_ZQCL: begin
               next_pins = PIN_ZQ;
               next_addr[AP_BIT] = 1'b1;
            end
            REQ_ZQCS: next_pins = PIN_ZQ;
            REQ_NOP: next_pins = PIN_NOP;
         endcase
      end
   end

   // Command pins are held for one full memory clock
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= PIN_DESEL;
         o_ba <= '0;
         o_addr <= '0;
      end else if (tick) begin
         {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= next_pins;
         o_ba <= i_req_bank;
         o_addr <= next_addr;
      end
   end

   // Request answers, one cycle pulses
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_req_ack <= 1'b0;
         o_req_reject <= 1'b0;
      end else begin
         o_req_ack <= fire;
         o_req_reject <= tick && i_req_valid && !legal;
      end
   end

   // Read beats owed to the capture logic
   assign rd_add = fire_read;
   assign rd_beats = i_req_bc4 ? BEAT_W'(BEATS_BC4) : BEAT_W'(BEATS_BL8);

   read_capture u_capture (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_dqs(i_dqs),
      .i_dq(i_dq),
      .i_add(rd_add),
      .i_add_beats(rd_beats),
      .o_data(o_rd_data),
      .o_valid(o_rd_valid)
   );

endmodule // ddr_cmd_sched

/* File: ddr_host_chk.sv */
`timescale 1ns/1ps
module ddr_host_chk (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic o_req_ack,
   input wire logic o_req_reject,
   input wire logic o_zq_busy,
   input wire logic o_ck,
   input wire logic o_cke,
   input wire logic o_cs_n,
   input wire logic o_ras_n,
   input wire logic o_cas_n,
   input wire logic o_we_n,
   input wire logic [ddr_host_pkg::BANK_W-1:0] o_ba,
   input wire logic [ddr_host_pkg::ROW_W-1:0] o_addr,
   input wire logic o_odt
);
   import ddr_host_pkg::*;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   logic [3:0] pins;
   logic [11:0] since_rd;
   logic [BANK_W-1:0] rd_bank;
   assign pins = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
   // Cycles since the last issued read and its bank
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         since_rd <= 12'hfff;
         rd_bank <= 3'h0;
      end else if (o_req_ack && pins == PIN_READ) begin
         since_rd <= 12'h1;
         rd_bank <= o_ba;
      end else if (since_rd != 12'hfff) begin
         since_rd <= since_rd + 12'h1;
      end
   end
   sequence ck_low4; !o_ck [*4]; endsequence
   sequence ck_high4; o_ck [*4]; endsequence
   sequence cmd_hold; $stable({pins, o_ba, o_addr}) [*7]; endsequence
   a_ck_shape: assert property ($fell(o_ck) |-> ck_low4 ##1 ck_high4 ##1 !o_ck) else $error("memory clock shape");
   a_cmd_stands: assert property (o_req_ack |=> cmd_hold ##1 (pins == PIN_NOP || o_req_ack)) else $error("command hold");
   a_ack_on_fall: assert property (o_req_ack |-> $fell(o_ck)) else $error("command off clock fall");
   a_answer_pulse: assert property ((o_req_ack || o_req_reject) |=> !(o_req_ack || o_req_reject)) else $error("answer pulse");
   a_cal_pins: assert property (!i_sys_rst |=> o_cke && !o_odt) else $error("cke or odt in run");
   a_zq_quiet: assert property (o_zq_busy && o_req_ack |-> pins == PIN_ZQ) else $error("command in calibration");
   a_rd_rd: assert property (o_req_ack && pins == PIN_READ |-> since_rd >= TCCD_CK * 8) else $error("read spacing");
   a_rd_wr: assert property (o_req_ack && pins == PIN_WRITE |-> since_rd >= RD_TO_WR_CK * 8) else $error("read to write");
   a_rd_pre: assert property (o_req_ack && pins == PIN_PRE && o_ba == rd_bank |-> since_rd >= RD_TO_PRE_CK * 8)
      else $error("read to precharge");
endmodule // ddr_host_chk
bind ddr_cmd_sched ddr_host_chk ddr_host_chk_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .o_req_ack(o_req_ack),
   .o_req_reject(o_req_reject), .o_zq_busy(o_zq_busy), .o_ck(o_ck), .o_cke(o_cke), .o_cs_n(o_cs_n),
   .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_ba(o_ba), .o_addr(o_addr), .o_odt(o_odt));

/* File: ddr_dev_model.sv */
`timescale 1ns/1ps
module ddr_dev_model (
   input wire logic i_ck,
   input wire logic [3:0] i_pins,
   input wire logic [ddr_host_pkg::BANK_W-1:0] i_ba,
   input wire logic [ddr_host_pkg::ROW_W-1:0] i_addr,
   output logic o_dqs,
   output logic [ddr_host_pkg::DQ_W-1:0] o_dq,
   output int o_errs
);
   import ddr_host_pkg::*;
   int n, busy, last_rd, zq_end, zq_count;
   logic [BANK_W-1:0] rd_bank;
   logic open [N_BANK];
   // One read burst: preamble, beats on both edges, then data inverted if no other burst runs
   task automatic burst(input int beats, input logic [7:0] base);
      repeat (RL - 1) @(posedge i_ck);
      if (busy == 0) o_dqs = 1'b0;
      busy++;
      @(posedge i_ck);
      for (int i = 0; i < beats; i++) begin
         o_dq = base + 8'(i);
         o_dqs = ~i[0];
         #(TCK_PS / 2000);
      end
      if (busy == 1) o_dq = ~o_dq;
      busy--;
   endtask
   initial begin
      o_dqs = 1'b0;
      o_dq = 8'h0;
      o_errs = 0;
      n = 0;
      busy = 0;
      last_rd = -100;
      zq_end = 0;
      zq_count = 0;
      rd_bank = 3'h0;
      foreach (open[b]) open[b] = 1'b0;
   end
   // Decode at each memory clock rise and police the spacings
   always @(posedge i_ck) begin
      n++;
      if (i_pins != PIN_NOP && i_pins != PIN_DESEL && i_pins != PIN_ZQ && n < zq_end) o_errs++;
      case (i_pins)
         PIN_ACT: begin
            if (open[i_ba]) o_errs++;
            open[i_ba] = 1'b1;
         end
         PIN_READ: begin
            if (!open[i_ba] || n - last_rd < TCCD_CK) o_errs++;
            last_rd = n;
            rd_bank = i_ba;
            if (i_addr[AP_BIT]) open[i_ba] = 1'b0;
            fork
               burst(i_addr[BL_BIT] ? BEATS_BL8 : BEATS_BC4, i_addr[7:0]);
            join_none
         end
         PIN_WRITE: if (n - last_rd < RD_TO_WR_CK) o_errs++;
         PIN_PRE: begin
            if (i_ba == rd_bank && n - last_rd < RD_TO_PRE_CK) o_errs++;
            open[i_ba] = 1'b0;
         end
         PIN_ZQ: begin
            foreach (open[b]) if (open[b]) o_errs++;
            zq_end = n + (i_addr[AP_BIT] ? (zq_count == 0 ? ZQINIT_CK : ZQOPER_CK) : ZQCS_CK);
            zq_count++;
         end
         default: ;
      endcase
   end
endmodule // ddr_dev_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import ddr_host_pkg::*;
   logic i_clock = 1'b0, i_sys_rst = 1'b1, i_req_valid = 1'b0, i_req_auto_pre = 1'b0, i_req_bc4 = 1'b0;
   req_cmd_type i_req_cmd = REQ_NOP;
   logic [BANK_W-1:0] i_req_bank = 3'h0;
   logic [ROW_W-1:0] i_req_row = 14'h0;
   logic [COL_W-1:0] i_req_col = 10'h0;
   logic o_req_ack, o_req_reject, o_zq_busy, o_ck, o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n, o_odt, o_rd_valid;
   logic [BANK_W-1:0] o_ba;
   logic [ROW_W-1:0] o_addr;
   logic [DQ_W-1:0] o_rd_data, dq;
   logic dqs;
   int fails = 0, total_checks = 0, cyc = 0, t_ack = 0, t_prev = 0, errs, b, r, c;
   logic [7:0] exp_q [$];
   always #12.5 i_clock = ~i_clock;
   ddr_cmd_sched ddr_cmd_sched_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
      .i_req_cmd(i_req_cmd), .i_req_bank(i_req_bank), .i_req_row(i_req_row), .i_req_col(i_req_col),
      .i_req_auto_pre(i_req_auto_pre), .i_req_bc4(i_req_bc4), .o_req_ack(o_req_ack), .o_req_reject(o_req_reject),
      .o_zq_busy(o_zq_busy), .o_ck(o_ck), .o_cke(o_cke), .o_cs_n(o_cs_n), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n),
      .o_we_n(o_we_n), .o_ba(o_ba), .o_addr(o_addr), .o_odt(o_odt), .i_dqs(dqs), .i_dq(dq),
      .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid));
   ddr_dev_model ddr_dev_model_i (.i_ck(o_ck), .i_pins({o_cs_n, o_ras_n, o_cas_n, o_we_n}), .i_ba(o_ba),
      .i_addr(o_addr), .o_dqs(dqs), .o_dq(dq), .o_errs(errs));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task print_verdict;
      $display("Checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Cycle count and hang guard
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         print_verdict;
      end
   end
   // Each captured beat against the queued expectation
   always @(negedge i_clock) begin
      if (o_rd_valid === 1'b1) begin
         if (exp_q.size() == 0) check("extra beat", 1, 0);
         else check("read data", o_rd_data, exp_q.pop_front());
      end
   end
   // One request, held until answered, then the answer checked
   task req(input req_cmd_type cmd, input int bk, input int rw, input int cl, input logic ap, input logic bc,
         input logic want_rej);
      int k;
      i_req_cmd = cmd;
      i_req_bank = 3'(bk);
      i_req_row = 14'(rw);
      i_req_col = 10'(cl);
      i_req_auto_pre = ap;
      i_req_bc4 = bc;
      i_req_valid = 1'b1;
      for (k = 0; k < 6000; k++) begin
         @(negedge i_clock);
         if (o_req_ack === 1'b1 || o_req_reject === 1'b1) break;
      end
      check("answer", {o_req_ack, o_req_reject}, {~want_rej, want_rej});
      if (o_req_ack === 1'b1) begin
         t_prev = t_ack;
         t_ack = cyc;
         if (cmd == REQ_READ) for (int j = 0; j < (bc ? BEATS_BC4 : BEATS_BL8); j++) exp_q.push_back(8'(cl + j));
      end
      i_req_valid = 1'b0;
      @(negedge i_clock);
   endtask
   task zq(input req_cmd_type cmd, input int len);
      int tz;
      req(cmd, 0, 0, 0, 1'b0, 1'b0, 1'b0);
      tz = t_ack;
      check("zq busy", o_zq_busy, 1);
      req(REQ_ACT, 0, 5, 0, 1'b0, 1'b0, 1'b0);
      check("quiet time", t_ack - tz >= len * 8 && t_ack - tz <= len * 8 + 8, 1);
      req(REQ_PRE, 0, 0, 0, 1'b0, 1'b0, 1'b0);
   endtask
   task drain(input string name);
      for (int k = 0; k < 400 && exp_q.size() != 0; k++) @(negedge i_clock);
      repeat (40) @(negedge i_clock);
      check("beats left", exp_q.size(), 0);
      check("device spacing faults", errs, 0);
      $display("Test %s finished", name);
   endtask
   initial begin
      void'($urandom(96));
      repeat (16) @(negedge i_clock);
      check("cke in reset", o_cke, 0);
      check("pins in reset", {o_cs_n, o_ras_n, o_cas_n, o_we_n}, PIN_DESEL);
      i_sys_rst = 1'b0;
      zq(REQ_ZQCL, ZQINIT_CK);
      zq(REQ_ZQCS, ZQCS_CK);
      zq(REQ_ZQCL, ZQOPER_CK);
      drain("calibration");
      for (b = 0; b < 5; b++) begin
         req(REQ_ACT, b, b, 0, 1'b0, 1'b0, 1'b0);
         if (b > 0) check("act spacing", t_ack - t_prev, RRD_CK * 8);
      end
      for (b = 0; b < 5; b++) req(REQ_PRE, b, 0, 0, 1'b0, 1'b0, 1'b0);
      drain("activate");
      b = $urandom % 8;
      r = $urandom % 16384;
      c = ($urandom % 128) * 8;
      req(REQ_ACT, b, r, 0, 1'b0, 1'b0, 1'b0);
      req(REQ_ACT, b, r, 0, 1'b0, 1'b0, 1'b1);
      req(REQ_READ, b, r + 1, c, 1'b0, 1'b0, 1'b1);
      req(REQ_READ, (b + 1) % 8, r, c, 1'b0, 1'b0, 1'b1);
      req(REQ_ZQCS, 0, 0, 0, 1'b0, 1'b0, 1'b1);
      req(REQ_READ, b, r, c, 1'b0, 1'b0, 1'b0);
      req(REQ_READ, b, r, c + 8, 1'b0, 1'b0, 1'b0);
      check("read read", t_ack - t_prev, TCCD_CK * 8);
      req(REQ_READ, b, r, c + 16, 1'b0, 1'b1, 1'b0);
      check("read bc4", t_ack - t_prev, TCCD_CK * 8);
      req(REQ_WRITE, b, r, c, 1'b0, 1'b0, 1'b0);
      check("read write", t_ack - t_prev, RD_TO_WR_CK * 8);
      req(REQ_READ, b, r, c, 1'b0, 1'b0, 1'b0);
      req(REQ_PRE, b, 0, 0, 1'b0, 1'b0, 1'b0);
      check("read pre", t_ack - t_prev, RD_TO_PRE_CK * 8);
      req(REQ_PRE, b, 0, 0, 1'b0, 1'b0, 1'b0);
      drain("read");
      for (int it = 0; it < 3; it++) begin
         b = $urandom % 8;
         r = $urandom % 16384;
         c = ($urandom % 128) * 8;
         req(REQ_ACT, b, r, 0, 1'b0, 1'b0, 1'b0);
         req(REQ_READ, b, r, c, 1'b1, 1'($urandom % 2), 1'b0);
         req(REQ_READ, b, r, c, 1'b0, 1'b0, 1'b1);
         req(REQ_ACT, b, r + 1, 0, 1'b0, 1'b0, 1'b0);
         check("auto pre to act", t_ack - t_prev, (RD_AP_CK + RP_CK) * 8);
         req(REQ_PRE, b, 0, 0, 1'b0, 1'b0, 1'b0);
      end
      drain("auto precharge");
      print_verdict;
   end
endmodule // tb_top
